// ---- rtl/adc_cfg_defines.svh ----
// offsets, field positions, reset values and codes for the adc config link
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// ==========================================================================
// device register offsets on the link
`define ADDR_RESULT        4'h0
`define ADDR_IRQ_CFG       4'h5
`define ADDR_MUX           4'h6

// ==========================================================================
// interrupt_pin_config fields, and reset values of it and the mux register
`define IRQ_POR_BIT        4
`define IRQ_CRC_BIT        5
`define IRQ_DR_BIT         6
`define IRQ_PINSEL_BIT     3
`define IRQ_IDLE_BIT       2
`define IRQ_FAST_BIT       1
`define IRQ_STP_BIT        0
`define IRQ_CFG_RESET      4'h3
`define MUX_RESET          8'h01

// ==========================================================================
// input selection codes
`define SEL_RESERVED       4'hA
`define SEL_DIODE_P        4'hD
`define SEL_DIODE_M        4'hE
`define MUX_TEMP_PAIR      8'hDE

// ==========================================================================
// host apb register offsets and fields
`define APB_CTRL           8'h00
`define APB_STATUS         8'h04
`define APB_INT_STATUS     8'h08
`define APB_INT_MASK       8'h0C
`define CTRL_WRITE_BIT     16
`define CTRL_FAST_BIT      17
`define CTRL_TEMP_BIT      18
`define INT_DONE_BIT       0
`define INT_REFUSED_BIT    1
`define INT_PIN_BIT        2

`endif

// ---- rtl/adc_cfg_device.sv ----
// device end: interrupt pin configuration and input mux selection
`timescale 1ns/1ns
`include "adc_cfg_defines.svh"
module adc_cfg_device (
  adc_cfg_link.dev             link,                  // host link
  input  logic                 sys_clk,               // system clock
  input  logic                 rst,                   // async reset
  input  logic                 por_event,             // power-on seen, pulse
  input  logic                 crc_error,             // config crc bad, level
  input  logic                 conv_start,            // conversion start pulse
  input  logic                 modulator_bit,         // modulator bitstream
  input  logic [15:0]          conversion_data,       // normal result
  output adc_cfg_pkg::sel_code_type positive_input_select, // vin+ code
  output adc_cfg_pkg::sel_code_type negative_input_select, // vin- code
  output logic                 diode_bias_enable,     // diode bias current
  output logic                 fast_cmd_valid,        // decoded fast command
  output logic [7:0]           fast_cmd_code          // its code
);
  import adc_cfg_pkg::*;

  // ========================================================================
  // state
  logic [3:0]     irq_cfg_reg;
  logic [3:0]     irq_cfg_next;
  logic           por_flag_reg;
  logic           por_flag_next;
  logic           crc_err_reg;
  logic           crc_err_next;
  logic           stp_pend_reg;
  logic           stp_pend_next;
  logic [7:0]     mux_reg;
  logic [7:0]     mux_next;
  logic [15:0]    modulator_bitstream_out_shift_reg;
  logic [15:0]    modulator_bitstream_out_shift_next;
  logic           ack_reg;
  logic           ack_next;
  link_rdata_type rdata_reg;
  link_rdata_type rdata_next;
  logic           pin_out_reg;
  logic           pin_out_next;
  logic           pin_oe_n_reg;
  logic           pin_oe_n_next;
  logic           bias_reg;
  logic           bias_next;
  logic           fast_valid_reg;
  logic           fast_valid_next;
  logic [7:0]     fast_code_reg;
  logic [7:0]     fast_code_next;

  // ========================================================================
  // decode helpers
  logic access;
  logic wr_irq;
  logic wr_mux;
  logic rd_irq;
  logic pin_bitstream;
  logic prio_irq;
  logic any_irq;
  logic [7:0] irq_view;

  // a request is served once, in the cycle before ack rises
  assign access  = link.sel && !ack_reg;
  assign wr_irq  = access && link.wr && (link.addr == `ADDR_IRQ_CFG);
  assign wr_mux  = access && link.wr && (link.addr == `ADDR_MUX);
  assign rd_irq  = access && !link.wr && (link.addr == `ADDR_IRQ_CFG);
  assign pin_bitstream = irq_cfg_reg[`IRQ_PINSEL_BIT];
  // power-on and crc are the only sources allowed over the bitstream
  assign prio_irq = !por_flag_reg || crc_err_reg;
  assign any_irq  = prio_irq || (stp_pend_reg && irq_cfg_reg[`IRQ_STP_BIT]);

  // read image of the interrupt_pin_config register; data-ready reads idle
  always_comb begin
    irq_view = 8'h00;
    irq_view[`IRQ_DR_BIT]  = 1'b1;
    irq_view[`IRQ_CRC_BIT] = !crc_err_reg;
    irq_view[`IRQ_POR_BIT] = por_flag_reg;
    irq_view[3:0]          = irq_cfg_reg;
  end

  // ========================================================================
  // next-state logic
  always_comb begin
    irq_cfg_next    = irq_cfg_reg;
    por_flag_next   = por_flag_reg;
    stp_pend_next   = stp_pend_reg;
    mux_next        = mux_reg;
    crc_err_next    = crc_error;
    ack_next        = access;
    rdata_next      = rdata_reg;
    fast_valid_next = 1'b0;
    fast_code_next  = fast_code_reg;

    if (wr_irq) begin
      irq_cfg_next = link.wdata[3:0];
    end
    if (wr_mux) begin
      mux_next = link.wdata;
    end

    // flag cleared by read, event wins
    if (rd_irq) begin
      por_flag_next = 1'b1;
      stp_pend_next = 1'b0;
    end
    if (por_event) begin
      por_flag_next = 1'b0;
    end
    // start event latched only while enabled; set wins over read clear
    if (conv_start && irq_cfg_reg[`IRQ_STP_BIT]) begin
      stp_pend_next = 1'b1;
    end

    // register reads
    if (access && !link.wr) begin
      unique case (link.addr)
        `ADDR_RESULT:
          rdata_next = pin_bitstream ? modulator_bitstream_out_shift_reg : conversion_data;
        `ADDR_IRQ_CFG: rdata_next = {8'h00, irq_view};
        `ADDR_MUX:     rdata_next = {8'h00, mux_reg};
        default:       rdata_next = 16'h0000;
      endcase
    end

    if (link.cmd_valid && irq_cfg_reg[`IRQ_FAST_BIT]) begin
      fast_valid_next = 1'b1;
      fast_code_next  = link.cmd_code;
    end
  end

  // modulator codes collected only while the pin is set to bitstream mode, even while power-on or crc holds it low
  always_comb begin
    modulator_bitstream_out_shift_next = modulator_bitstream_out_shift_reg;
    if (pin_bitstream) begin
      modulator_bitstream_out_shift_next = {modulator_bitstream_out_shift_reg[14:0], modulator_bit};
    end
  end

  // ========================================================================
  // shared pin drive; interrupt is active low
  always_comb begin
    if (pin_bitstream) begin
      pin_out_next  = prio_irq ? 1'b0 : modulator_bit;
      pin_oe_n_next = 1'b0;
    end else if (any_irq) begin
      pin_out_next  = 1'b0;
      pin_oe_n_next = 1'b0;
    end else begin
      pin_out_next  = 1'b1;
      pin_oe_n_next = !irq_cfg_reg[`IRQ_IDLE_BIT];
    end
  end

  always_comb begin
    bias_next = (mux_reg[7:4] == `SEL_DIODE_P) ||
                (mux_reg[7:4] == `SEL_DIODE_M) ||
                (mux_reg[3:0] == `SEL_DIODE_P) ||
                (mux_reg[3:0] == `SEL_DIODE_M);
  end

  // ========================================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_cfg_reg    <= `IRQ_CFG_RESET;
      por_flag_reg   <= 1'b1;
      crc_err_reg    <= 1'b0;
      stp_pend_reg   <= 1'b0;
      mux_reg        <= `MUX_RESET;
      modulator_bitstream_out_shift_reg <= 16'h0000;
      ack_reg        <= 1'b0;
      rdata_reg      <= 16'h0000;
      pin_out_reg    <= 1'b1;
      pin_oe_n_reg   <= 1'b1;
      bias_reg       <= 1'b0;
      fast_valid_reg <= 1'b0;
      fast_code_reg  <= 8'h00;
    end else begin
      irq_cfg_reg    <= irq_cfg_next;
      por_flag_reg   <= por_flag_next;
      crc_err_reg    <= crc_err_next;
      stp_pend_reg   <= stp_pend_next;
      mux_reg        <= mux_next;
      modulator_bitstream_out_shift_reg <= modulator_bitstream_out_shift_next;
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      pin_out_reg    <= pin_out_next;
      pin_oe_n_reg   <= pin_oe_n_next;
      bias_reg       <= bias_next;
      fast_valid_reg <= fast_valid_next;
      fast_code_reg  <= fast_code_next;
    end
  end

  // ========================================================================
  // outputs, all from flops
  assign link.ack              = ack_reg;
  assign link.rdata            = rdata_reg;
  assign link.pin_out          = pin_out_reg;
  assign link.pin_oe_n         = pin_oe_n_reg;
  assign positive_input_select = mux_reg[7:4];
  assign negative_input_select = mux_reg[3:0];
  assign diode_bias_enable     = bias_reg;
  assign fast_cmd_valid        = fast_valid_reg;
  assign fast_cmd_code         = fast_code_reg;
endmodule

// ---- rtl/adc_cfg_host.sv ----
// host end: apb-programmed controller that drives the adc config link
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "adc_cfg_defines.svh"
module adc_cfg_host #(
  parameter int INPUT_COUNT = 8  // single-ended inputs: 8, 4 or 2
) (
  adc_cfg_link.host link,        // device link
  input  logic        sys_clk,   // system clock
  input  logic        rst,       // async reset
  input  logic        psel,      // apb select
  input  logic        penable,   // apb access phase
  input  logic        pwrite,    // apb write
  input  logic [7:0]  paddr,     // apb byte address
  input  logic [31:0] pwdata,    // apb write data
  output logic [31:0] prdata,    // apb read data
  output logic        pready,    // apb ready
  output logic        pslverr,   // apb error, unmapped address
  output logic        irq        // level interrupt
);
  import adc_cfg_pkg::*;

  host_state_type state_reg, state_next;
  logic        sel_reg, sel_next, wr_reg, wr_next;
  logic [3:0]  addr_reg, addr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        cmd_reg, cmd_next;
  logic [7:0]  cmd_code_reg, cmd_code_next;
  logic [15:0] last_rdata_reg, last_rdata_next;
  logic [2:0]  int_status_reg, int_status_next;
  logic [2:0]  int_mask_reg, int_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        irq_reg, irq_next;
  logic        pin_prev_reg, pin_prev_next;
  logic        pin_sync;
  logic        apb_take;
  logic        ctrl_wr;
  logic [7:0]  req_data;
  logic        bad_code;

  // the device pin is asynchronous to us
  adc_cfg_sync #(.RESET_VALUE(1'b1)) pin_sync_inst (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (link.pin_level),
    .sync_out (pin_sync)
  );

  // codes the host may not program for this variant
  function automatic logic code_bad(input logic [3:0] c);
    logic r;
    r = (c == `SEL_RESERVED);
    if (INPUT_COUNT == 4 && c >= 4'h4 && c <= 4'h7) r = 1'b1;
    if (INPUT_COUNT == 2 && c >= 4'h2 && c <= 4'h7) r = 1'b1;
    return r;
  endfunction

  // ========================================================================
  // apb decode; answer comes in the first cycle of the access phase
  assign apb_take = psel && penable && pready_reg;
  assign ctrl_wr  = apb_take && pwrite && (paddr == `APB_CTRL);
  assign req_data = pwdata[`CTRL_TEMP_BIT] ? `MUX_TEMP_PAIR : pwdata[15:8];
  assign bad_code = !pwdata[`CTRL_FAST_BIT] &&
                    (pwdata[`CTRL_WRITE_BIT] || pwdata[`CTRL_TEMP_BIT]) &&
                    (pwdata[`CTRL_TEMP_BIT] || pwdata[3:0] == `ADDR_MUX) &&
                    (code_bad(req_data[7:4]) || code_bad(req_data[3:0]));

  always_comb begin
    state_next      = state_reg;
    sel_next        = sel_reg;
    wr_next         = wr_reg;
    addr_next       = addr_reg;
    wdata_next      = wdata_reg;
    cmd_next        = 1'b0;
    cmd_code_next   = cmd_code_reg;
    last_rdata_next = last_rdata_reg;
    int_status_next = int_status_reg;
    int_mask_next   = int_mask_reg;
    pready_next     = psel && !penable;
    pslverr_next    = 1'b0;
    prdata_next     = 32'h0000_0000;
    pin_prev_next   = pin_sync;

    // apb reads; interrupt status clears on read, events below win
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `APB_STATUS:     prdata_next = {14'h0, pin_sync,
                                        last_rdata_reg,
                                        state_reg == HOST_REQ};
        `APB_INT_STATUS: prdata_next = {29'h0, int_status_reg};
        `APB_INT_MASK:   prdata_next = {29'h0, int_mask_reg};
        `APB_CTRL:       prdata_next = 32'h0000_0000;
        default:         pslverr_next = 1'b1;
      endcase
    end
    if (psel && !penable && pwrite &&
        !(paddr inside {`APB_CTRL, `APB_STATUS,
                        `APB_INT_STATUS, `APB_INT_MASK})) begin
      pslverr_next = 1'b1;
    end
    // clear only what was reported, so an event after setup is kept
    if (apb_take && !pwrite && paddr == `APB_INT_STATUS) begin
      int_status_next = int_status_reg & ~prdata_reg[2:0];
    end
    if (apb_take && pwrite && paddr == `APB_INT_MASK) begin
      int_mask_next = pwdata[2:0];
    end

    unique case (state_reg)
      HOST_IDLE: begin
        if (ctrl_wr) begin
          if (pwdata[`CTRL_FAST_BIT]) begin
            cmd_next      = 1'b1;
            cmd_code_next = pwdata[15:8];
            int_status_next[`INT_DONE_BIT] = 1'b1;
          end else if (bad_code) begin
            int_status_next[`INT_REFUSED_BIT] = 1'b1;
          end else begin
            sel_next   = 1'b1;
            wr_next    = pwdata[`CTRL_WRITE_BIT] || pwdata[`CTRL_TEMP_BIT];
            addr_next  = pwdata[`CTRL_TEMP_BIT] ? `ADDR_MUX : pwdata[3:0];
            wdata_next = req_data;
            state_next = HOST_REQ;
          end
        end
      end
      HOST_REQ: begin
        // busy: new orders are dropped and flagged
        if (ctrl_wr) begin
          int_status_next[`INT_REFUSED_BIT] = 1'b1;
        end
        if (link.ack) begin
          sel_next        = 1'b0;
          last_rdata_next = link.rdata;
          int_status_next[`INT_DONE_BIT] = 1'b1;
          state_next      = HOST_IDLE;
        end
      end
    endcase

    // pin falling edge marks a device interrupt
    if (pin_prev_reg && !pin_sync) begin
      int_status_next[`INT_PIN_BIT] = 1'b1;
    end
    irq_next = |(int_status_reg & int_mask_reg);
  end

  // ========================================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= HOST_IDLE;
      sel_reg        <= 1'b0;
      wr_reg         <= 1'b0;
      addr_reg       <= 4'h0;
      wdata_reg      <= 8'h00;
      cmd_reg        <= 1'b0;
      cmd_code_reg   <= 8'h00;
      last_rdata_reg <= 16'h0000;
      int_status_reg <= 3'b000;
      int_mask_reg   <= 3'b000;
      prdata_reg     <= 32'h0000_0000;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      irq_reg        <= 1'b0;
      pin_prev_reg   <= 1'b1;
    end else begin
      state_reg      <= state_next;
      sel_reg        <= sel_next;
      wr_reg         <= wr_next;
      addr_reg       <= addr_next;
      wdata_reg      <= wdata_next;
      cmd_reg        <= cmd_next;
      cmd_code_reg   <= cmd_code_next;
      last_rdata_reg <= last_rdata_next;
      int_status_reg <= int_status_next;
      int_mask_reg   <= int_mask_next;
      prdata_reg     <= prdata_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      irq_reg        <= irq_next;
      pin_prev_reg   <= pin_prev_next;
    end
  end

  assign link.sel       = sel_reg;
  assign link.wr        = wr_reg;
  assign link.addr      = addr_reg;
  assign link.wdata     = wdata_reg;
  assign link.cmd_valid = cmd_reg;
  assign link.cmd_code  = cmd_code_reg;
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign irq            = irq_reg;
endmodule

// ---- rtl/adc_cfg_link.sv ----
// link between the host controller and the adc configuration logic
`timescale 1ns/1ns
interface adc_cfg_link;
  logic                       sel;        // register request held
  logic                       wr;         // request is a write
  adc_cfg_pkg::link_addr_type addr;       // register offset
  logic [7:0]                 wdata;      // write data
  adc_cfg_pkg::link_rdata_type rdata;     // read data, valid with ack
  logic                       ack;        // one-cycle answer
  logic                       cmd_valid;  // command byte strobe
  logic [7:0]                 cmd_code;   // command byte
  logic                       pin_out;    // shared pin drive value
  logic                       pin_oe_n;   // low while device drives pin
  logic                       pin_level;  // resolved wire level

  // ========================================================================
  // wire resolution: released pin is pulled up externally
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;

  modport dev (input sel, wr, addr, wdata, cmd_valid, cmd_code,
               output rdata, ack, pin_out, pin_oe_n);
  modport host (output sel, wr, addr, wdata, cmd_valid, cmd_code,
                input rdata, ack, pin_level);
endinterface

// ---- rtl/adc_cfg_pkg.sv ----
// types shared by both ends of the adc config link
package adc_cfg_pkg;
  typedef logic [3:0]  sel_code_type;
  typedef logic [3:0]  link_addr_type;
  typedef logic [15:0] link_rdata_type;
  typedef enum logic [0:0] {HOST_IDLE, HOST_REQ} host_state_type;
endpackage

// ---- rtl/adc_cfg_sync.sv ----
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module adc_cfg_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  logic sys_clk,   // system clock
  input  logic rst,       // async reset, active high
  input  logic async_in,  // level from outside
  output logic sync_out   // synchronised level
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // ========================================================================
  // first flop feeds only the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ---- verif/adc_cfg_sva.sv ----
// checker for the adc config link between host and device ends
`timescale 1ns/1ns
module adc_cfg_sva #(
  parameter int INPUT_COUNT = 8  // single-ended inputs on this variant
) (
  input logic                        sys_clk,  // system clock
  input logic                        rst,      // async reset
  input logic                        sel,      // request held
  input logic                        wr,       // request is a write
  input adc_cfg_pkg::link_addr_type  addr,     // device offset
  input logic [7:0]                  wdata,    // write data
  input adc_cfg_pkg::link_rdata_type rdata,    // read data
  input logic                        ack,      // device answer
  input logic                        cmd_valid, // command strobe
  input logic                        pin_out,  // pin drive value
  input logic                        pin_oe_n  // low while driven
);
  import adc_cfg_pkg::*;
  logic [3:0] cfg_q;
  logic [7:0] mux_q;
  logic       flt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ========================================================================
  // shadow of the device config, updated when a write is answered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 4'h3;
      mux_q <= 8'h01;
    end else if (sel && wr && ack) begin
      if (addr == 4'h5) cfg_q <= wdata[3:0];
      if (addr == 4'h6) mux_q <= wdata;
    end
  end
  // codes wired to floating inputs on this variant
  assign flt = (int'(wdata[7:4]) inside {[INPUT_COUNT:7]}) ||
               (int'(wdata[3:0]) inside {[INPUT_COUNT:7]});
  // ========================================================================
  // link handshake
  a_ack_one_cycle: assert property (sel && !ack |=> ack)
    else $error("ack late");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_sel_held: assert property (sel && !ack |=> sel && $stable(addr))
    else $error("request dropped early");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe too long");
  // ========================================================================
  // register contents
  a_cfg_readback: assert property (
    ack && !wr && addr == 4'h5 |->
      rdata[3:0] == cfg_q && rdata[7:6] == 2'b01 && rdata[15:8] == 8'h00)
    else $error("config read wrong");
  a_mux_readback: assert property (
    ack && !wr && addr == 4'h6 |-> rdata == {8'h00, mux_q})
    else $error("mux read wrong");
  a_unmapped_zero: assert property (
    ack && !wr && !(addr inside {4'h0, 4'h5, 4'h6}) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_no_reserved: assert property (
    sel && wr && addr == 4'h6 |-> wdata[7:4] != 4'hA && wdata[3:0] != 4'hA)
    else $error("reserved code sent");
  a_no_floating: assert property (
    sel && wr && addr == 4'h6 |-> !flt)
    else $error("floating input code sent");
  // ========================================================================
  // shared pin drive
  a_bitstream_drv: assert property (
    cfg_q[3] && $past(cfg_q[3]) |-> !pin_oe_n)
    else $error("pin released in bitstream mode");
  a_float_idle: assert property (
    !cfg_q[3] && !cfg_q[2] && $stable(cfg_q) |-> pin_oe_n || !pin_out)
    else $error("pin driven high while floating idle");
  a_high_idle: assert property (
    !cfg_q[3] && cfg_q[2] && $stable(cfg_q) |-> !pin_oe_n)
    else $error("pin released while idle high");
endmodule

// ---- verif/tb_irq_pin_config_and_input_mux_select.sv ----
// testbench: apb host driving the device end over the config link
`timescale 1ns/1ns
module tb_irq_pin_config_and_input_mux_select;
  import adc_cfg_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic por_event, crc_error, conv_start, modulator_bit, bias, fcv;
  logic [7:0]   paddr, fcc;
  logic [31:0]  pwdata, prdata, q;
  logic [15:0]  conversion_data, v;
  sel_code_type pos_sel, neg_sel;
  int num_errors = 0;
  int cmp_count  = 0;
  int fast_seen  = 0;
  adc_cfg_link i_adc_cfg_link ();
  adc_cfg_host #(.INPUT_COUNT(4)) i_adc_cfg_host (.link(i_adc_cfg_link),
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  adc_cfg_device i_adc_cfg_device (.link(i_adc_cfg_link), .sys_clk(sys_clk),
    .rst(rst), .por_event(por_event), .crc_error(crc_error),
    .conv_start(conv_start), .modulator_bit(modulator_bit),
    .conversion_data(conversion_data), .positive_input_select(pos_sel),
    .negative_input_select(neg_sel), .diode_bias_enable(bias),
    .fast_cmd_valid(fcv), .fast_cmd_code(fcc));
  adc_cfg_sva #(.INPUT_COUNT(4)) i_adc_cfg_sva (.sys_clk(sys_clk),
    .rst(rst), .sel(i_adc_cfg_link.sel), .wr(i_adc_cfg_link.wr),
    .addr(i_adc_cfg_link.addr), .wdata(i_adc_cfg_link.wdata),
    .rdata(i_adc_cfg_link.rdata), .ack(i_adc_cfg_link.ack),
    .cmd_valid(i_adc_cfg_link.cmd_valid),
    .pin_out(i_adc_cfg_link.pin_out), .pin_oe_n(i_adc_cfg_link.pin_oe_n));
  // ========================================================================
  // clock, fast command counter and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (fcv === 1'b1) fast_seen <= fast_seen + 1;
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test;
  end
  // ========================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin num_errors++; end_of_test; end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20);
    if (st[0] !== 1'b0) begin num_errors++; end_of_test; end
  endtask
  task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] st;
    apb(1'b1, 8'h00, {15'h0, 1'b1, d, 4'h0, a}, st);
    wait_idle(st);
  endtask
  task automatic dev_rd(input logic [3:0] a, output logic [15:0] r);
    logic [31:0] st;
    apb(1'b1, 8'h00, {28'h0, a}, st);
    wait_idle(st);
    r = st[16:1];
  endtask
  task pulse(input logic por);
    @(posedge sys_clk);
    if (por) por_event <= 1'b1;
    else conv_start <= 1'b1;
    @(posedge sys_clk);
    por_event <= 1'b0; conv_start <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // ========================================================================
  // main sequence
  initial begin
    logic       ok;
    logic [7:0] em;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; por_event = 1'b0; crc_error = 1'b0; conv_start = 1'b0;
    modulator_bit = 1'b0; conversion_data = 16'h1234;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    dev_rd(4'h5, v); chk(v, 32'h73);
    dev_rd(4'h6, v); chk(v, 32'h01);
    dev_rd(4'h3, v); chk(v, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q); chk(last_err, 1'b1);
    // power-on event pulls the pin and raises the unmasked interrupt
    apb(1'b1, 8'h0C, 32'h4, q);
    pulse(1'b1); chk(irq, 1'b1);
    dev_rd(4'h5, v); chk(v, 32'h63);
    dev_rd(4'h5, v); chk(v, 32'h73);
    apb(1'b0, 8'h08, 32'h0, q); chk(q[2], 1'b1);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    pulse(1'b0); apb(1'b0, 8'h04, 32'h0, q); chk(q[17], 1'b0);
    dev_rd(4'h5, v);
    dev_wr(4'h5, 8'h06); pulse(1'b0);
    apb(1'b0, 8'h04, 32'h0, q); chk(q[17], 1'b1);
    // fast command decoded, then ignored by the device once disabled
    apb(1'b1, 8'h00, 32'h0002_5A00, q); repeat (4) @(posedge sys_clk);
    chk(fast_seen, 1); chk(fcc, 8'h5A);
    dev_wr(4'h5, 8'h04);
    apb(1'b1, 8'h00, 32'h0002_3C00, q); repeat (4) @(posedge sys_clk);
    chk(fast_seen, 1);
    // bitstream mode: result and pin carry the modulator, power-on wins
    modulator_bit <= 1'b1;
    dev_wr(4'h5, 8'h08); repeat (20) @(posedge sys_clk);
    dev_rd(4'h0, v); chk(v, 32'hFFFF);
    apb(1'b0, 8'h04, 32'h0, q); chk(q[17], 1'b1);
    crc_error <= 1'b1;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0, q); chk(q[17], 1'b0);
    dev_rd(4'h5, v); chk(v, 32'h58);
    crc_error <= 1'b0;
    pulse(1'b1); apb(1'b0, 8'h04, 32'h0, q); chk(q[17], 1'b0);
    dev_wr(4'h5, 8'h03);
    dev_rd(4'h5, v); chk(v, 32'h63);
    dev_rd(4'h0, v); chk(v, 32'h1234);
    // temperature pair, then every selection code on both fields
    apb(1'b1, 8'h00, 32'h0004_0000, q); wait_idle(q);
    chk({pos_sel, neg_sel, bias}, {8'hDE, 1'b1});
    em = 8'hDE;
    for (int c = 0; c < 16; c++) begin
      ok = !(c inside {[4:7], 10});
      if (ok) em = {c[3:0], c[3:0]};
      dev_wr(4'h6, {c[3:0], c[3:0]});
      apb(1'b0, 8'h08, 32'h0, q); chk(q[1], !ok);
      chk({pos_sel, neg_sel}, em);
      chk(bias, em[7:4] inside {4'hD, 4'hE});
    end
    end_of_test;
  end
endmodule
